/* File: hdl/pcg_dev.sv */
module pcg_dev
  import pcg_pkg::*;
(
  input  wire logic   REF_CLK,
  input  wire logic   RESETN,
  pcg_link_if.dev     link,
  output logic        MEM_REQ,
  output logic        REG_REQ,
  output logic        ACC_WE,
  output logic [16:0] ACC_ADDR,
  output logic [1:0]  ACC_BE,
  output logic [15:0] ACC_WDATA,
  input  wire logic [15:0] ACC_RDATA,
  input  wire logic   ACC_ACK,
  output logic        CFG_DONE,
  output logic        BIG_ENDIAN,
  output logic        GENERIC_MODE2,
  output logic        FAMILY_OK
);
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_WAIT = 2'b01,
    D_DONE = 2'b10
  } pcg_dstate_e;

  pcg_dstate_e st_q;
  logic [4:0]  strb_s;
  logic        cs_s, rd_s, rdwr_s, we0_s, we1_s;
  logic        act_rd, act_wr;
  logic [1:0]  be_raw;
  logic [16:0] ad;
  logic        cfg_done_q, big_q, mode2_q, fam_q;
  logic        mem_req_q, reg_req_q, we_q, wait_n_q, oe_q;
  logic [16:0] addr_q;
  logic [1:0]  be_q;
  logic [15:0] wdata_q, rdata_q;

  // ****************************************
  // strobe synchroniser
  // ****************************************
  pcg_sync #(.W(5), .INI(5'h1f)) u_sync (
    .REF_CLK (REF_CLK),
    .RESETN  (RESETN),
    .d       ({link.cs_n, link.rd_n, link.rd_wr_n, link.we0_n, link.we1_n}),
    .q       (strb_s)
  );
  assign {cs_s, rd_s, rdwr_s, we0_s, we1_s} = strb_s;

  // ****************************************
  // strap capture
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cfg_done_q <= 1'b0;
      big_q      <= 1'b0;
      mode2_q    <= 1'b0;
      fam_q      <= 1'b0;
    end
    else if (!cfg_done_q)
    begin
      // caught once after release, then frozen until next reset
      cfg_done_q <= 1'b1;
      big_q      <= link.config_straps[ENDIAN_BIT];
      mode2_q    <= link.bus_status_strap;
      fam_q      <= (link.config_straps[2:0] == FAMILY_GEN);
    end
  end

  // ****************************************
  // strobe decode per generic mode
  // ****************************************
  assign act_rd = mode2_q ? !rd_s : (!rd_s || !rdwr_s);
  assign act_wr = mode2_q ? !we0_s : (!we0_s || !we1_s);
  assign be_raw = mode2_q ? {!we1_s, !link.ab[0]} :
                  (act_wr ? {!we1_s, !we0_s} : {!rdwr_s, !rd_s});
  assign ad     = {link.ab[16:1], 1'b0};

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_q      <= D_IDLE;
      mem_req_q <= 1'b0;
      reg_req_q <= 1'b0;
      we_q      <= 1'b0;
      wait_n_q  <= 1'b1;
      oe_q      <= 1'b0;
      addr_q    <= '0;
      be_q      <= '0;
      wdata_q   <= '0;
      rdata_q   <= '0;
    end
    else
    begin
      mem_req_q <= 1'b0;
      reg_req_q <= 1'b0;
      unique case (st_q)
        D_IDLE:
        begin
          if (fam_q && !cs_s && (act_rd || act_wr))
          begin
            wait_n_q <= 1'b0;
            we_q     <= act_wr;
            addr_q   <= ad;
            be_q     <= big_q ? {be_raw[0], be_raw[1]} : be_raw;
            wdata_q  <= big_q ? swap16(link.db) : link.db;
            rdata_q  <= '0;
            if (in_mem(ad))
            begin
              mem_req_q <= 1'b1;
              st_q      <= D_WAIT;
            end
            else if (in_reg(ad))
            begin
              reg_req_q <= 1'b1;
              st_q      <= D_WAIT;
            end
            else
            begin
              // hole in the window: writes dropped, reads return zero
              st_q <= D_DONE;
            end
          end
        end
        D_WAIT:
        begin
          if (ACC_ACK)
          begin
            rdata_q <= big_q ? swap16(ACC_RDATA) : ACC_RDATA;
            st_q    <= D_DONE;
          end
        end
        D_DONE:
        begin
          wait_n_q <= 1'b1;
          oe_q     <= !we_q && act_rd && !cs_s;
          if (cs_s || !(act_rd || act_wr))
          begin
            oe_q <= 1'b0;
            st_q <= D_IDLE;
          end
        end
        default:
        begin
          st_q <= D_IDLE;
        end
      endcase
    end
  end

  assign link.wait_n    = wait_n_q;
  assign link.dev_db_oe = oe_q;
  assign link.dev_db_o  = rdata_q;
  assign MEM_REQ        = mem_req_q;
  assign REG_REQ        = reg_req_q;
  assign ACC_WE         = we_q;
  assign ACC_ADDR       = addr_q;
  assign ACC_BE         = be_q;
  assign ACC_WDATA      = wdata_q;
  assign CFG_DONE       = cfg_done_q;
  assign BIG_ENDIAN     = big_q;
  assign GENERIC_MODE2  = mode2_q;
  assign FAMILY_OK      = fam_q;
endmodule : pcg_dev

/* File: hdl/pcg_host.sv */
module pcg_host
  import pcg_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  pcg_link_if.host         link,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [4:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        STRAP_BIG,
  input  wire logic        STRAP_MODE2,
  output logic             CARD_SUPPRESS_N
);
  typedef enum logic [2:0] {
    G_IDLE  = 3'b000,
    G_LATCH = 3'b001,
    G_STRB  = 3'b010,
    G_WAIT  = 3'b011,
    G_REL   = 3'b100
  } pcg_hstate_e;

  pcg_hstate_e st_q;
  logic        ack_q;
  logic [31:0] dat_o_q;
  logic [31:0] addr_q, cfg_q;
  logic [15:0] wdata_q, rdata_q;
  logic        wr_q, busy_q, done_q, miss_q;
  logic [1:0]  be_q;
  logic [1:0]  pin_be;
  logic        wb_wr, go_req, done_clr, miss_clr, hit;
  logic        ale_q;
  logic [3:0]  ab_hi_q;
  logic [12:0] ab_lo_q;
  logic        cs_n_q, rd_n_q, rdwr_n_q, we0_n_q, we1_n_q, oe_q;
  logic        sup_n_q, big_q, mode2_q;
  logic [2:0]  cnt_q;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    wb_merge = r;
  endfunction : wb_merge

  function automatic logic slot_hit(input logic [31:0] a,
                                    input logic [31:0] c);
    logic win;
    logic ok;
    win = 1'b0;
    ok  = 1'b0;
    if (c[CFG_BUF])
      win = (a[31:24] == BUF_WIN_TOP);
    else
      // bits 25..17 left open, attribute space not looked at
      win = (a[31:26] == SLOT1_MEM_TOP) ||
            ((a[31:24] == SLOT1_IO_TOP) && !c[CFG_IOEN]);
    ok = !c[CFG_NOAL] || (a[23:17] == 7'h00);
    slot_hit = win && ok;
  endfunction : slot_hit

  // ****************************************
  // wishbone slave
  // ****************************************
  assign wb_wr    = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_q;
  assign go_req   = wb_wr && (WB_ADR_I == OFS_CTRL) && WB_SEL_I[0] &&
                    WB_DAT_I[CTRL_GO] && !busy_q;
  assign done_clr = wb_wr && (WB_ADR_I == OFS_STATUS) && WB_SEL_I[0] &&
                    WB_DAT_I[ST_DONE];
  assign miss_clr = wb_wr && (WB_ADR_I == OFS_STATUS) && WB_SEL_I[0] &&
                    WB_DAT_I[ST_MISS];
  assign hit      = slot_hit(addr_q, cfg_q);
  // enables swapped like the data, so the far end swaps them back
  assign pin_be   = big_q ? {be_q[0], be_q[1]} : be_q;

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ack_q   <= 1'b0;
      dat_o_q <= '0;
    end
    else
    begin
      ack_q   <= WB_CYC_I && WB_STB_I && !ack_q;
      dat_o_q <= '0;
      if (WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_q)
      begin
        unique case (WB_ADR_I)
          OFS_CTRL:   dat_o_q <= {28'h0000000, be_q, wr_q, 1'b0};
          OFS_ADDR:   dat_o_q <= addr_q;
          OFS_WDATA:  dat_o_q <= {16'h0000, wdata_q};
          OFS_RDATA:  dat_o_q <= {16'h0000, rdata_q};
          OFS_STATUS: dat_o_q <= {29'h0000000, miss_q, done_q, busy_q};
          OFS_CFG:    dat_o_q <= cfg_q;
          default:    dat_o_q <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      addr_q  <= '0;
      cfg_q   <= CFG_RESET;
      wdata_q <= '0;
      wr_q    <= 1'b0;
      be_q    <= 2'b11;
    end
    else if (wb_wr && !busy_q)
    begin
      // order registers frozen while a slot cycle runs
      unique case (WB_ADR_I)
        OFS_ADDR:  addr_q <= wb_merge(addr_q, WB_DAT_I, WB_SEL_I);
        OFS_CFG:   cfg_q  <= wb_merge(cfg_q, WB_DAT_I, WB_SEL_I);
        OFS_WDATA: wdata_q <= 16'(wb_merge({16'h0000, wdata_q}, WB_DAT_I,
                                           WB_SEL_I));
        OFS_CTRL:
        begin
          if (WB_SEL_I[0])
          begin
            wr_q <= WB_DAT_I[CTRL_WR];
            be_q <= {WB_DAT_I[CTRL_BE1], WB_DAT_I[CTRL_BE0]};
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // ****************************************
  // straps, held for the device to catch
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      big_q   <= 1'b0;
      mode2_q <= 1'b0;
    end
    else
    begin
      big_q   <= STRAP_BIG;
      mode2_q <= STRAP_MODE2;
    end
  end

  // ****************************************
  // slot cycle sequencer
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_q     <= G_IDLE;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      miss_q   <= 1'b0;
      rdata_q  <= '0;
      ale_q    <= 1'b0;
      ab_hi_q  <= '0;
      ab_lo_q  <= '0;
      cs_n_q   <= 1'b1;
      rd_n_q   <= 1'b1;
      rdwr_n_q <= 1'b1;
      we0_n_q  <= 1'b1;
      we1_n_q  <= 1'b1;
      oe_q     <= 1'b0;
      sup_n_q  <= 1'b1;
      cnt_q    <= '0;
    end
    else
    begin
      // clear first so a same-cycle set below wins
      if (done_clr)
        done_q <= 1'b0;
      if (miss_clr)
        miss_q <= 1'b0;
      unique case (st_q)
        G_IDLE:
        begin
          if (go_req && hit)
          begin
            busy_q  <= 1'b1;
            ale_q   <= 1'b1;
            ab_hi_q <= addr_q[16:LATCH_LSB];
            ab_lo_q <= addr_q[LATCH_LSB-1:0];
            sup_n_q <= !cfg_q[CFG_BUF];
            st_q    <= G_LATCH;
          end
          else if (go_req)
            miss_q <= 1'b1;
        end
        G_LATCH:
        begin
          ale_q  <= 1'b0;
          cs_n_q <= 1'b0;
          cnt_q  <= '0;
          oe_q   <= wr_q;
          if (mode2_q)
          begin
            ab_lo_q[0] <= !pin_be[0];
            rd_n_q     <= wr_q;
            we0_n_q    <= !wr_q;
            we1_n_q    <= !pin_be[1];
          end
          else
          begin
            rd_n_q   <= wr_q || !pin_be[0];
            rdwr_n_q <= wr_q || !pin_be[1];
            we0_n_q  <= !(wr_q && pin_be[0]);
            we1_n_q  <= !(wr_q && pin_be[1]);
          end
          st_q <= G_STRB;
        end
        G_STRB:
        begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == SETTLE_CNT)
            st_q <= G_WAIT;
        end
        G_WAIT:
        begin
          if (link.wait_n)
          begin
            rdata_q  <= big_q ? swap16(link.db) : link.db;
            rd_n_q   <= 1'b1;
            rdwr_n_q <= 1'b1;
            we0_n_q  <= 1'b1;
            we1_n_q  <= 1'b1;
            st_q     <= G_REL;
          end
        end
        G_REL:
        begin
          cs_n_q  <= 1'b1;
          oe_q    <= 1'b0;
          sup_n_q <= 1'b1;
          busy_q  <= 1'b0;
          done_q  <= 1'b1;
          st_q    <= G_IDLE;
        end
        default:
        begin
          st_q <= G_IDLE;
        end
      endcase
    end
  end

  // ale_q only gates host_db_oe: the host leaves the data bus undriven while it is high
  assign link.ab               = {ab_hi_q, ab_lo_q};
  assign link.host_db_o        = big_q ? swap16(wdata_q) : wdata_q;
  assign link.host_db_oe       = oe_q && !ale_q;
  assign link.cs_n             = cs_n_q;
  assign link.rd_n             = rd_n_q;
  assign link.rd_wr_n          = rdwr_n_q;
  assign link.we0_n            = we0_n_q;
  assign link.we1_n            = we1_n_q;
  assign link.config_straps    = {big_q, FAMILY_GEN};
  assign link.bus_status_strap = mode2_q;
  assign WB_DAT_O              = dat_o_q;
  assign WB_ACK_O              = ack_q;
  assign CARD_SUPPRESS_N       = sup_n_q;
endmodule : pcg_host

/* File: hdl/pcg_link_if.sv */
interface pcg_link_if;
  logic [16:0] ab;
  logic [15:0] host_db_o;
  logic        host_db_oe;
  logic [15:0] dev_db_o;
  logic        dev_db_oe;
  logic [15:0] db;
  logic        cs_n;
  logic        rd_n;
  logic        rd_wr_n;
  logic        we0_n;
  logic        we1_n;
  logic        wait_n;
  logic [3:0]  config_straps;
  logic        bus_status_strap;

  // undriven bus floats high through the pull-ups
  assign db = host_db_oe ? host_db_o : (dev_db_oe ? dev_db_o : 16'hffff);

  modport host (output ab, host_db_o, host_db_oe, cs_n, rd_n, rd_wr_n,
                output we0_n, we1_n, config_straps, bus_status_strap,
                input  db, wait_n);
  modport dev  (input  ab, db, cs_n, rd_n, rd_wr_n, we0_n, we1_n,
                input  config_straps, bus_status_strap,
                output dev_db_o, dev_db_oe, wait_n);
endinterface : pcg_link_if

/* File: hdl/pcg_pkg.sv */
package pcg_pkg;
  // ****************************************
  // link geometry
  // ****************************************
  localparam int          WIN_AW     = 17;
  localparam int          DW         = 16;
  localparam int          LATCH_LSB  = 13;
  localparam logic [16:0] MEM_LAST   = 17'h13fff;
  localparam logic [16:0] REG_FIRST  = 17'h1ffe0;
  localparam logic [16:0] REG_LAST   = 17'h1ffff;
  localparam logic [2:0]  FAMILY_GEN = 3'h7;
  localparam int          ENDIAN_BIT = 3;
  // host waits this long before trusting wait_n: 2-stage sync + 1 reg + 1 spare
  localparam int          SETTLE     = 4;
  localparam logic [2:0]  SETTLE_CNT = 3'h4;
  // ****************************************
  // host address map
  // ****************************************
  localparam logic [7:0]  SLOT1_IO_TOP  = 8'h08;
  localparam logic [7:0]  BUF_WIN_TOP   = 8'h09;
  localparam logic [5:0]  SLOT1_MEM_TOP = 6'h19;
  // ****************************************
  // wishbone register map
  // ****************************************
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_ADDR   = 5'h04;
  localparam logic [4:0] OFS_WDATA  = 5'h08;
  localparam logic [4:0] OFS_RDATA  = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_CFG    = 5'h14;
  localparam int CTRL_GO  = 0;
  localparam int CTRL_WR  = 1;
  localparam int CTRL_BE0 = 2;
  localparam int CTRL_BE1 = 3;
  localparam int ST_BUSY  = 0;
  localparam int ST_DONE  = 1;
  localparam int ST_MISS  = 2;
  localparam int CFG_BUF  = 0;
  localparam int CFG_NOAL = 1;
  localparam int CFG_IOEN = 2;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  function automatic logic in_mem(input logic [16:0] a);
    in_mem = (a <= MEM_LAST);
  endfunction : in_mem

  function automatic logic in_reg(input logic [16:0] a);
    in_reg = (a >= REG_FIRST) && (a <= REG_LAST);
  endfunction : in_reg

  function automatic logic [15:0] swap16(input logic [15:0] d);
    swap16 = {d[7:0], d[15:8]};
  endfunction : swap16
endpackage : pcg_pkg

/* File: hdl/pcg_sync.sv */
module pcg_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] INI = '1
) (
  input  wire logic         REF_CLK,
  input  wire logic         RESETN,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      meta_q <= INI;
      q      <= INI;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : pcg_sync

/* File: verification/pc_card_host_glue_tb.sv */
module pc_card_host_glue_tb
  import pcg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_host_n = 1'b0;
  logic        rst_dev_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        wbwe = 1'b0;
  logic [4:0]  adr = 5'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dato;
  logic        ack, sup_n, mreq, rreq, awe, cdone, ben, gm2, fok;
  logic        big = 1'b0;
  logic        m2 = 1'b0;
  logic        aack = 1'b0;
  logic [16:0] aadr;
  logic [1:0]  abe;
  logic [15:0] awd;
  logic [15:0] ard = 16'h0;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          n_mem = 0;
  int          n_reg = 0;
  int          cnt = 0;
  int          sup_cnt = 0;
  integer      seed = 32'h9aa87c33;
  logic [16:0] corner [6] = '{17'h0, 17'h13ffe, 17'h14000,
                              17'h1ffde, 17'h1ffe0, 17'h1fffe};
  logic [31:0] bases [4] = '{32'h6400_0000, 32'h0800_0000,
                             32'h0900_0000, 32'h1000_0000};

  always #20 clk = ~clk;

  pcg_link_if pcg_link_if_i ();
  pcg_host pcg_host_i (.REF_CLK(clk), .RESETN(rst_host_n),
    .link(pcg_link_if_i), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wbwe),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dato),
    .WB_ACK_O(ack), .STRAP_BIG(big), .STRAP_MODE2(m2),
    .CARD_SUPPRESS_N(sup_n));
  pcg_dev pcg_dev_i (.REF_CLK(clk), .RESETN(rst_dev_n),
    .link(pcg_link_if_i), .MEM_REQ(mreq), .REG_REQ(rreq), .ACC_WE(awe),
    .ACC_ADDR(aadr), .ACC_BE(abe), .ACC_WDATA(awd), .ACC_RDATA(ard),
    .ACC_ACK(aack), .CFG_DONE(cdone), .BIG_ENDIAN(ben),
    .GENERIC_MODE2(gm2), .FAMILY_OK(fok));
  pcg_props pcg_props_i (.REF_CLK(clk), .RESETN(rst_dev_n),
    .ab(pcg_link_if_i.ab), .db(pcg_link_if_i.db),
    .host_db_oe(pcg_link_if_i.host_db_oe),
    .dev_db_oe(pcg_link_if_i.dev_db_oe), .cs_n(pcg_link_if_i.cs_n),
    .rd_n(pcg_link_if_i.rd_n), .rd_wr_n(pcg_link_if_i.rd_wr_n),
    .we0_n(pcg_link_if_i.we0_n), .we1_n(pcg_link_if_i.we1_n),
    .wait_n(pcg_link_if_i.wait_n),
    .config_straps(pcg_link_if_i.config_straps),
    .bus_status_strap(pcg_link_if_i.bus_status_strap));

  // ****************************************
  // access-port responder, random latency
  // ****************************************
  always @(posedge clk)
  begin
    aack <= 1'b0;
    if (sup_n === 1'b0) sup_cnt++;
    if (mreq === 1'b1 || rreq === 1'b1)
    begin
      n_mem += (mreq === 1'b1);
      n_reg += (rreq === 1'b1);
      cnt = 1 + ($random(seed) & 3);
    end
    else if (cnt == 1)
    begin
      aack <= 1'b1;
      ard <= 16'($random(seed));
      cnt = 0;
    end
    else if (cnt > 1) cnt--;
  end

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [4:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wbwe <= w;
    adr <= a;
    wdat <= d;
    // no cycle limit here: only the watchdog ends a stuck wait
    do
      @(posedge clk);
    while (ack !== 1'b1);
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // 0 miss, 1 memory, 2 registers, 3 hole inside the window
  function automatic int kind(input logic [31:0] a, input logic [2:0] c);
    logic hit;
    if (c[CFG_BUF]) hit = (a[31:24] == BUF_WIN_TOP);
    else hit = (a[31:26] == SLOT1_MEM_TOP) ||
               (a[31:24] == SLOT1_IO_TOP && !c[CFG_IOEN]);
    if (c[CFG_NOAL] && a[23:17] != 7'h0) hit = 1'b0;
    if (!hit) return 0;
    if (a[16:0] <= MEM_LAST) return 1;
    if (a[16:0] >= REG_FIRST) return 2;
    return 3;
  endfunction : kind

  task automatic xfer(input logic [31:0] a, input logic [2:0] c,
                      input logic w);
    logic [31:0] q, d;
    logic [1:0]  be;
    int k, m0, r0, s0;
    d = {16'h0, 16'($random(seed))};
    be = 2'($random(seed));
    // in mode one no enable at all starts no transfer, so fall back to both bytes
    if (be == 2'h0)
      be = 2'h3;
    k = kind(a, c);
    m0 = n_mem;
    r0 = n_reg;
    s0 = sup_cnt;
    wb(1'b1, OFS_CFG, {29'h0, c}, q);
    wb(1'b1, OFS_ADDR, a, q);
    wb(1'b1, OFS_WDATA, d, q);
    wb(1'b1, OFS_CTRL, {28'h0, be, w, 1'b1}, q);
    do
      wb(1'b0, OFS_STATUS, 32'h0, q);
    while (q[2:1] === 2'b00);
    chk("miss", q[ST_MISS], k == 0);
    chk("memreq", n_mem - m0, k == 1);
    chk("regreq", n_reg - r0, k == 2);
    chk("suppress", sup_cnt > s0, k != 0 && c[CFG_BUF]);
    if (k == 1 || k == 2)
    begin
      chk("addr", aadr, {a[16:1], 1'b0});
      chk("dir", awe, w);
      chk("be", abe, be);
      if (w) chk("wdata", awd, d[15:0]);
    end
    wb(1'b1, OFS_STATUS, 32'h6, q);
    // window hole reads zero, mapped reads return the responder's word
    if (!w && k != 0)
    begin
      wb(1'b0, OFS_RDATA, 32'h0, q);
      chk("rdata", q, (k == 3) ? 32'h0 : {16'h0, ard});
    end
  endtask : xfer

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [31:0] q, r;
    logic [16:0] off;
    repeat (12) @(posedge clk);
    rst_host_n <= 1'b1;
    wb(1'b0, OFS_CFG, 32'h0, q);
    chk("cfg_reset", q, CFG_RESET);
    wb(1'b1, 5'h18, 32'hffff_ffff, q);
    wb(1'b0, 5'h18, 32'h0, q);
    chk("unmapped", q, 32'h0);
    for (int p = 0; p < 4; p++)
    begin
      // device held alone so it takes the straps the host now shows
      rst_dev_n <= 1'b0;
      big <= p[0];
      m2 <= p[1];
      repeat (3) @(posedge clk);
      rst_dev_n <= 1'b1;
      repeat (3) @(posedge clk);
      big <= !p[0];
      m2 <= !p[1];
      repeat (3) @(posedge clk);
      chk("big", ben, p[0]);
      chk("mode2", gm2, p[1]);
      chk("family", {cdone, fok}, 2'b11);
      big <= p[0];
      m2 <= p[1];
      repeat (3) @(posedge clk);
      for (int i = 0; i < 6; i++)
      begin
        xfer(32'h67fe_0000 | 32'(corner[i]), 3'h0, i[0]);
        xfer(32'h09fe_0000 | 32'(corner[i]), 3'h1, !i[0]);
      end
      for (int i = 0; i < 16; i++)
      begin
        r = $random(seed);
        off = r[4] ? corner[r[7:5] % 6] : 17'($random(seed)) & 17'h1fffe;
        xfer(bases[r[9:8]] | {8'h0, r[16:10], off}, r[19:17], r[20]);
      end
    end
    print_verdict();
  end

  initial
  begin
    #800000;
    fail_count++;
    $display("BAD watchdog exp finish seen timeout");
    print_verdict();
  end
endmodule : pc_card_host_glue_tb

/* File: verification/pcg_props.sv */
module pcg_props
  import pcg_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        RESETN,
  input wire logic [16:0] ab,
  input wire logic [15:0] db,
  input wire logic        host_db_oe,
  input wire logic        dev_db_oe,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        rd_wr_n,
  input wire logic        we0_n,
  input wire logic        we1_n,
  input wire logic        wait_n,
  input wire logic [3:0]  config_straps,
  input wire logic        bus_status_strap
);
  // ****************************************
  // link checks, device reset domain
  // ****************************************
  // disabled while the device is held, since its straps are not yet taken
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  a_family_fixed: assert property (
    config_straps[2:0] == FAMILY_GEN)
    else $error("family straps not all high");
  a_mode2_rdwr: assert property (
    bus_status_strap |-> rd_wr_n)
    else $error("read-write line low in mode two");
  a_strobe_in_cs: assert property (
    (!rd_n || !rd_wr_n || !we0_n || !we1_n) |-> !cs_n)
    else $error("strobe outside chip select");
  a_cs_gap: assert property (
    $rose(cs_n) |=> cs_n)
    else $error("chip select not released between cycles");
  a_cs_bounded: assert property (
    $fell(cs_n) |-> ##[1:60] cs_n)
    else $error("chip select held too long");
  a_addr_held: assert property (
    (!cs_n && $past(!cs_n)) |-> $stable(ab))
    else $error("latched address moved in a cycle");
  a_wait_answer: assert property (
    $fell(cs_n) |-> ##[1:6] !wait_n)
    else $error("no wait answer to strobes");
  a_wait_idle: assert property (
    cs_n [*4] |-> wait_n)
    else $error("wait held with no cycle");
  a_no_clash: assert property (
    !(host_db_oe && dev_db_oe))
    else $error("both ends drive the data bus");
  a_wdata_held: assert property (
    (!we0_n && host_db_oe && $past(!we0_n && host_db_oe)) |-> $stable(db))
    else $error("write data moved under strobe");
endmodule : pcg_props
